// ### rtl/hpba_params.svh
`ifndef HPBA_PARAMS_SVH
`define HPBA_PARAMS_SVH

`define HPBA_ADDR_W 7
`define HPBA_DATA_W 8
`define HPBA_CLK_MHZ 250
// Settling time before acknowledge, in ns, and its cycle count
`define HPBA_ACK_SETTLE_NS 8
`define HPBA_ACK_SETTLE_CYC ((`HPBA_ACK_SETTLE_NS * `HPBA_CLK_MHZ + 999) / 1000)
`define HPBA_RST_ADDR 7'h00
`define HPBA_RST_DATA 8'h00

`endif

// ### rtl/hpba_pkg.sv
package hpba_pkg;
  typedef enum logic [1:0] {
    HPBA_IDLE = 2'b00,
    HPBA_WRITE = 2'b01,
    HPBA_READ = 2'b10,
    HPBA_ACK = 2'b11
  } hpba_state_e;
endpackage

// ### rtl/hpba_edge.sv
// Registered edge detector for synchronous strobe inputs
module hpba_edge (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Level in, edges out
  input wire logic i_level,
  output logic o_rise,
  output logic o_fall
);
  logic prev_reg;
  logic prev_next;

  always_comb
  begin
    prev_next = i_level;
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
      prev_reg <= 1'b1;
    else
      prev_reg <= prev_next;
  end

  assign o_rise = i_level & ~prev_reg;
  assign o_fall = ~i_level & prev_reg;
endmodule

// ### rtl/hpba_port.sv
`include "hpba_params.svh"

module hpba_port
  import hpba_pkg::*;
#(
  parameter int ADDR_W = `HPBA_ADDR_W,
  parameter int DATA_W = `HPBA_DATA_W,
  parameter int SETTLE_CYC = `HPBA_ACK_SETTLE_CYC
) (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // Host bus pins
  input wire logic i_bus_style_strap,
  input wire logic i_cs_n,
  input wire logic i_address_latch_strobe,
  input wire logic i_read_or_data_strobe,
  input wire logic i_write_or_rw_select,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_data,
  output logic [DATA_W-1:0] o_data,
  output logic o_data_oe,
  output logic o_ready_acknowledge_out,
  // Storage side
  output logic o_wr_pulse,
  output logic [ADDR_W-1:0] o_wr_addr,
  output logic [DATA_W-1:0] o_wr_data,
  output logic [ADDR_W-1:0] o_rd_addr,
  input wire logic [DATA_W-1:0] i_rd_data,
  output logic o_burst_active
);
  localparam int CNT_W = $clog2(SETTLE_CYC + 1);

  logic als_rise;
  logic als_fall;
  logic ds_rise;
  logic ds_fall;
  logic wr_rise;
  logic wr_fall;
  logic ds_style;
  logic ds_strobe;
  logic wr_strobe;
  logic is_read;

  hpba_edge u_als (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_level(i_address_latch_strobe),
    .o_rise(als_rise),
    .o_fall(als_fall)
  );
  hpba_edge u_ds (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_level(ds_strobe),
    .o_rise(ds_rise),
    .o_fall(ds_fall)
  );
  hpba_edge u_wr (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_level(wr_strobe),
    .o_rise(wr_rise),
    .o_fall(wr_fall)
  );

  // Strap is sampled continuously; it is expected to be tied
  assign ds_style = i_bus_style_strap;
  // Chip select gates the data and write strobes, so a deselected port sees them high
  assign ds_strobe = i_read_or_data_strobe | i_cs_n;
  assign wr_strobe = i_write_or_rw_select | i_cs_n | ds_style;
  assign is_read = i_write_or_rw_select;

  hpba_state_e state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic first_reg, first_next;
  logic burst_reg, burst_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic [DATA_W-1:0] dout_reg, dout_next;
  logic oe_reg, oe_next;
  logic ack_reg, ack_next;
  logic wp_reg, wp_next;
  logic [DATA_W-1:0] wd_reg, wd_next;

  always_comb
  begin
    state_next = state_reg;
    addr_next = addr_reg;
    first_next = first_reg;
    burst_next = burst_reg;
    cnt_next = cnt_reg;
    dout_next = dout_reg;
    oe_next = oe_reg;
    ack_next = ack_reg;
    wp_next = 1'b0;
    wd_next = wd_reg;
    // Address latching and burst end; latching also restarts the burst
    if (!ds_style && als_rise)
    begin
      burst_next = 1'b0;
    end
    else if (ds_style && als_fall)
    begin
      burst_next = 1'b0;
    end
    if (!i_cs_n && ((!ds_style && als_fall) || (ds_style && als_rise)))
    begin
      addr_next = i_addr;
      first_next = 1'b1;
      burst_next = 1'b1;
    end
    case (state_reg)
      HPBA_IDLE:
      begin
        if (!ds_style && wr_fall)
        begin
          // Later cycles step the address; wrap is natural overflow
          if (!first_reg && burst_reg)
            addr_next = ADDR_W'(addr_reg + 1'b1);
          first_next = 1'b0;
          state_next = HPBA_WRITE;
        end
        else if (ds_style && ds_fall && is_read)
        begin
          if (!first_reg && burst_reg)
            addr_next = ADDR_W'(addr_reg + 1'b1);
          first_next = 1'b0;
          oe_next = 1'b1;
          cnt_next = '0;
          state_next = HPBA_READ;
        end
      end
      HPBA_WRITE:
      begin
        if (wr_rise)
        begin
          wp_next = 1'b1;
          wd_next = i_data;
          state_next = HPBA_IDLE;
        end
      end
      HPBA_READ:
      begin
        dout_next = i_rd_data;
        // Wait for storage data to settle before acknowledging
        if (cnt_reg == CNT_W'(SETTLE_CYC))
        begin
          ack_next = 1'b0;
          state_next = HPBA_ACK;
        end
        else
          cnt_next = CNT_W'(cnt_reg + 1'b1);
        if (ds_rise)
        begin
          oe_next = 1'b0;
          // Release wins over a same-cycle acknowledge, else it sticks low
          ack_next = 1'b1;
          state_next = HPBA_IDLE;
        end
      end
      default:
      begin
        if (ds_rise)
        begin
          oe_next = 1'b0;
          ack_next = 1'b1;
          state_next = HPBA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg <= HPBA_IDLE;
      addr_reg <= `HPBA_RST_ADDR;
      first_reg <= 1'b1;
      burst_reg <= 1'b0;
      cnt_reg <= '0;
      dout_reg <= `HPBA_RST_DATA;
      oe_reg <= 1'b0;
      ack_reg <= 1'b1;
      wp_reg <= 1'b0;
      wd_reg <= `HPBA_RST_DATA;
    end
    else
    begin
      state_reg <= state_next;
      addr_reg <= addr_next;
      first_reg <= first_next;
      burst_reg <= burst_next;
      cnt_reg <= cnt_next;
      dout_reg <= dout_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
      wp_reg <= wp_next;
      wd_reg <= wd_next;
    end
  end

  assign o_data = dout_reg;
  assign o_data_oe = oe_reg;
  assign o_ready_acknowledge_out = ack_reg;
  assign o_wr_pulse = wp_reg;
  assign o_wr_addr = addr_reg;
  assign o_wr_data = wd_reg;
  assign o_rd_addr = addr_reg;
  assign o_burst_active = burst_reg;
endmodule

// ### tb/hpba_chk.sv
module hpba_chk (
  // Watched pins
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_bus_style_strap,
  input wire logic i_cs_n,
  input wire logic i_address_latch_strobe,
  input wire logic i_read_or_data_strobe,
  input wire logic i_write_or_rw_select,
  input wire logic [6:0] i_addr,
  input wire logic [7:0] i_data,
  input wire logic o_data_oe,
  input wire logic o_ready_acknowledge_out,
  input wire logic o_wr_pulse,
  input wire logic [6:0] o_wr_addr,
  input wire logic [7:0] o_wr_data,
  input wire logic [6:0] o_rd_addr,
  input wire logic o_burst_active
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire sd = i_bus_style_strap & ~i_cs_n;
  wire sw = ~i_bus_style_strap & ~i_cs_n;
  wire rd = sd & i_write_or_rw_select;
  property p_lat_sep;
    $fell(i_address_latch_strobe) && sw |=> o_wr_addr == $past(i_addr) && o_burst_active;
  endproperty
  a_lat_sep: assert property (p_lat_sep) else $error("latch sep");
  property p_lat_ds;
    $rose(i_address_latch_strobe) && sd |=> o_rd_addr == $past(i_addr) && o_burst_active;
  endproperty
  a_lat_ds: assert property (p_lat_ds) else $error("latch ds");
  property p_end_sep;
    $rose(i_address_latch_strobe) && sw |=> !o_burst_active;
  endproperty
  a_end_sep: assert property (p_end_sep) else $error("end sep");
  property p_end_ds;
    $fell(i_address_latch_strobe) && sd |=> !o_burst_active;
  endproperty
  a_end_ds: assert property (p_end_ds) else $error("end ds");
  property p_oe;
    $fell(i_read_or_data_strobe) && rd |=> o_data_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("no drive");
  property p_ack;
    $fell(i_read_or_data_strobe) && rd |=> o_ready_acknowledge_out[*3] ##1 !o_ready_acknowledge_out;
  endproperty
  a_ack: assert property (p_ack) else $error("ack timing");
  property p_rel;
    $rose(i_read_or_data_strobe) && o_data_oe |=> !o_data_oe && o_ready_acknowledge_out;
  endproperty
  a_rel: assert property (p_rel) else $error("release");
  property p_cs;
    $fell(i_read_or_data_strobe) && i_cs_n && !o_data_oe |=> !o_data_oe;
  endproperty
  a_cs: assert property (p_cs) else $error("cs ignored");
  property p_wr;
    $rose(i_write_or_rw_select) && sw |=> o_wr_pulse && o_wr_data == $past(i_data);
  endproperty
  a_wr: assert property (p_wr) else $error("write");
  c_wr: cover property (o_wr_pulse);
  c_ack: cover property (!o_ready_acknowledge_out);
  c_end: cover property ($fell(o_burst_active));
endmodule

bind hpba_port hpba_chk hpba_chk_inst (.*);

// ### tb/hpba_mem.sv
module hpba_mem (
  input wire logic i_core_clk,
  input wire logic i_we,
  input wire logic [6:0] i_a,
  input wire logic [7:0] i_d,
  input wire logic [6:0] i_ra,
  output logic [7:0] o_q
);
  logic [7:0] m [128];
  // Preset so unwritten reads are distinct
  initial for (int i = 0; i < 128; i++) m[i] = 8'(i);
  always @(posedge i_core_clk) if (i_we) m[i_a] <= i_d;
  assign o_q = m[i_ra];
endmodule

// ### tb/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst, strap, cs_n, ale, ds, wr, oe, ack, we, burst;
  logic [6:0] addr, wa, ra;
  logic [7:0] din, dout, wd, rdd;
  int errors = 0;
  int total_checks = 0;
  hpba_port hpba_port_inst (.i_core_clk(clk), .i_rst(rst), .i_bus_style_strap(strap),
    .i_cs_n(cs_n), .i_address_latch_strobe(ale), .i_read_or_data_strobe(ds),
    .i_write_or_rw_select(wr), .i_addr(addr), .i_data(din), .o_data(dout), .o_data_oe(oe),
    .o_ready_acknowledge_out(ack), .o_wr_pulse(we), .o_wr_addr(wa), .o_wr_data(wd),
    .o_rd_addr(ra), .i_rd_data(rdd), .o_burst_active(burst));
  hpba_mem hpba_mem_inst (.i_core_clk(clk), .i_we(we), .i_a(wa), .i_d(wd), .i_ra(ra), .o_q(rdd));
  initial
  begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  task cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(string n, logic [7:0] e, logic [7:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("unexpected %s exp %h got %h", n, e, s);
      errors++;
    end
  endtask
  function automatic logic [7:0] expv(logic [6:0] a);
    return (a == 7'h7e || a == 7'h7f || a == 7'h00) ? 8'ha0 + 8'(7'(a + 7'h2)) : 8'(a);
  endfunction
  // Separate-strobe burst across the top address
  task t_wr;
    strap = 0;
    cs_n = 0;
    addr = 7'h7e;
    cyc(2);
    ale = 0;
    cyc(2);
    for (int k = 0; k < 3; k++)
    begin
      din = 8'ha0 + 8'(k);
      wr = 0;
      cyc(3);
      wr = 1;
      for (int w = 0; w < 8 && we !== 1'b1; w++) cyc(1);
      chk("wr_addr", 8'(7'(7'h7e + k)), 8'(wa));
      chk("wr_data", din, wd);
      chk("wr_pulse", 8'h01, 8'(we));
    end
    ale = 1;
    cyc(2);
    chk("burst", 8'h00, 8'(burst));
    $display("t_wr done");
  endtask
  // Data-strobe burst, also a fresh burst after an ended one
  task t_rd(logic [6:0] s);
    strap = 1;
    ale = 0;
    addr = s;
    wr = 1;
    cs_n = 0;
    cyc(2);
    ale = 1;
    cyc(2);
    for (int k = 0; k < 3; k++)
    begin
      ds = 0;
      for (int w = 0; w < 12 && ack !== 1'b0; w++) cyc(1);
      chk("oe", 8'h01, 8'(oe));
      chk("rd_data", expv(s + 7'(k)), dout);
      chk("rd_addr", 8'(7'(s + k)), 8'(ra));
      ds = 1;
      cyc(3);
    end
    ale = 0;
    cyc(2);
    chk("burst", 8'h00, 8'(burst));
    $display("t_rd done");
  endtask
  task t_cs;
    cs_n = 1;
    ds = 0;
    cyc(8);
    chk("oe_cs", 8'h00, 8'(oe));
    chk("ack_cs", 8'h01, 8'(ack));
    ds = 1;
    cyc(2);
    $display("t_cs done");
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    rst = 1;
    strap = 0;
    cs_n = 1;
    ale = 1;
    ds = 1;
    wr = 1;
    addr = 7'h00;
    din = 8'h00;
    cyc(16);
    rst = 0;
    cyc(2);
    t_wr;
    t_rd(7'h7f);
    t_rd(7'h7e);
    t_cs;
    tally_and_finish;
  end
  initial
  begin
    #20000;
    errors++;
    tally_and_finish;
  end
endmodule
